/* File: core/breaker_fail_timing.v */
`timescale 1ns/10ps
`default_nettype none
`include "breaker_fail_defs.vh"

module breaker_fail_timing #(
    parameter MS_CYCLES = `BF_TICK_US * `BF_CLK_MHZ
) (
    // Clock, reset, enable
    input  wire        clk_sys_in,
    input  wire        srst_in,
    input  wire        ce_in,
    // Pick-up sources and blocking input
    input  wire        phase_pickup_in,
    input  wire        residual_pickup_in,
    input  wire        trip_monitor_in,
    input  wire        ext_trip_in,
    input  wire        block_in,
    // Settings
    input  wire [1:0]  criterion_in,
    input  wire        retrip_en_in,
    input  wire [15:0] redundant_trip_delay_in,
    input  wire [15:0] fail_delay_in,
    input  wire [7:0]  event_on_mask_in,
    input  wire [7:0]  event_off_mask_in,
    input  wire [2:0]  setting_group_in,
    // Process data
    input  wire [15:0] max_phase_current_in,
    input  wire [15:0] residual_current_in,
    // Counter clear and log read
    input  wire        counter_clear_in,
    input  wire [3:0]  log_index_in,
    // Contacts and status
    output reg         retrip_out,
    output reg         breaker_fail_output,
    output reg         start_out,
    output reg         blocked_out,
    // Event stream
    output reg         event_valid_out,
    output reg  [2:0]  event_code_out,
    output reg         event_on_out,
    output reg  [31:0] event_time_out,
    // Cumulative counters
    output reg  [15:0] retrip_count_out,
    output reg  [15:0] fail_count_out,
    output reg  [15:0] start_count_out,
    output reg  [15:0] blocked_count_out,
    // Log read port
    output reg  [31:0] log_time_out,
    output reg  [2:0]  log_event_out,
    output reg  [15:0] log_phase_out,
    output reg  [15:0] log_resid_out,
    output reg  [15:0] log_to_retrip_out,
    output reg  [15:0] log_to_fail_out,
    output reg  [2:0]  log_group_out
);

    // ------------------------------------------------------------
    // Millisecond tick and time stamp
    // ------------------------------------------------------------
    reg  [31:0] tick_cnt_q;
    reg         ms_tick_q;
    reg  [31:0] stamp_q;

    always @(posedge clk_sys_in) begin
        if (srst_in) begin
            tick_cnt_q <= 32'h0000_0000;
            ms_tick_q  <= 1'b0;
            stamp_q    <= 32'h0000_0000;
        end else if (ce_in) begin
            ms_tick_q <= 1'b0;
            if (tick_cnt_q >= MS_CYCLES - 1) begin
                tick_cnt_q <= 32'h0000_0000;
                ms_tick_q  <= 1'b1;
            end else begin
                tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
            end
            if (ms_tick_q) begin
                stamp_q <= stamp_q + 32'h0000_0001;
            end
        end
    end

    // ------------------------------------------------------------
    // Pick-up selection
    // ------------------------------------------------------------
    wire cur_pu = phase_pickup_in | residual_pickup_in;
    reg  pickup;
    reg  run;

    always @* begin
        pickup = 1'b0;
        run    = 1'b0;
        case (criterion_in)
            `BF_CRIT_CUR: begin
                pickup = cur_pu;
                run    = cur_pu;
            end
            `BF_CRIT_CUR_AND: begin
                pickup = cur_pu;
                run    = cur_pu & trip_monitor_in;
            end
            `BF_CRIT_CUR_OR: begin
                pickup = cur_pu | trip_monitor_in;
                run    = pickup;
            end
            default: begin
                pickup = ext_trip_in;
                run    = ext_trip_in;
            end
        endcase
    end

    // Blocked start drops like a released pick-up
    wire start_d   = pickup & ~block_in;
    wire blocked_d = pickup & block_in;
    wire count_en  = start_d & run;

    // ------------------------------------------------------------
    // Delay timers in milliseconds
    // ------------------------------------------------------------
    reg  [20:0] elapsed_ms_q;
    wire [20:0] rt_limit = {5'h00, redundant_trip_delay_in} * `BF_STEP_MS;
    wire [20:0] bf_limit = {5'h00, fail_delay_in} * `BF_STEP_MS;
    wire        rt_use   = retrip_en_in & (criterion_in != `BF_CRIT_INPUT);

    always @(posedge clk_sys_in) begin
        if (srst_in) begin
            elapsed_ms_q        <= 21'h00_0000;
            retrip_out          <= 1'b0;
            breaker_fail_output <= 1'b0;
            start_out           <= 1'b0;
            blocked_out         <= 1'b0;
        end else if (ce_in) begin
            start_out   <= start_d;
            blocked_out <= blocked_d;
            if (!count_en) begin
                elapsed_ms_q <= 21'h00_0000;
            end else if (ms_tick_q && elapsed_ms_q != 21'h1f_ffff) begin
                elapsed_ms_q <= elapsed_ms_q + 21'h00_0001;
            end
            retrip_out <= count_en & rt_use & (elapsed_ms_q >= rt_limit);
            breaker_fail_output <= count_en & (elapsed_ms_q >= bf_limit);
        end
    end

    wire [20:0] rt_left = (elapsed_ms_q >= rt_limit) ? 21'h00_0000 : rt_limit - elapsed_ms_q;
    wire [20:0] bf_left = (elapsed_ms_q >= bf_limit) ? 21'h00_0000 : bf_limit - elapsed_ms_q;

    // ------------------------------------------------------------
    // Event generation
    // ------------------------------------------------------------
    wire [7:0] status = {residual_pickup_in, phase_pickup_in, ext_trip_in, trip_monitor_in,
                         blocked_out, breaker_fail_output, retrip_out, start_out};
    reg  [7:0] seen_q;
    wire [7:0] changed = status ^ seen_q;

    function [2:0] first_set;
        input [7:0] v;
        integer k;
        begin
            first_set = 3'h0;
            for (k = 7; k >= 0; k = k - 1) begin
                if (v[k]) begin
                    first_set = k[2:0];
                end
            end
        end
    endfunction

    wire [2:0] ev_src  = first_set(changed);
    wire       ev_any  = |changed;
    wire       ev_on   = status[ev_src];
    wire       ev_keep = ev_on ? event_on_mask_in[ev_src] : event_off_mask_in[ev_src];

    // One change is reported per cycle; the rest stay pending in seen_q
    always @(posedge clk_sys_in) begin
        if (srst_in) begin
            seen_q          <= 8'h00;
            event_valid_out <= 1'b0;
            event_code_out  <= 3'h0;
            event_on_out    <= 1'b0;
            event_time_out  <= 32'h0000_0000;
        end else if (ce_in) begin
            event_valid_out <= ev_any & ev_keep;
            if (ev_any) begin
                seen_q[ev_src] <= ev_on;
                event_code_out <= ev_src;
                event_on_out   <= ev_on;
                event_time_out <= stamp_q;
            end
        end
    end

    // ------------------------------------------------------------
    // Cumulative counters
    // ------------------------------------------------------------
    wire on_ev = ev_any & ev_on;

    always @(posedge clk_sys_in) begin
        if (srst_in || (ce_in && counter_clear_in)) begin
            retrip_count_out  <= 16'h0000;
            fail_count_out    <= 16'h0000;
            start_count_out   <= 16'h0000;
            blocked_count_out <= 16'h0000;
        end else if (ce_in && on_ev) begin
            if (ev_src == `BF_EV_RETRIP) retrip_count_out <= retrip_count_out + 16'h0001;
            if (ev_src == `BF_EV_FAIL) fail_count_out <= fail_count_out + 16'h0001;
            if (ev_src == `BF_EV_START) start_count_out <= start_count_out + 16'h0001;
            if (ev_src == `BF_EV_BLOCK) blocked_count_out <= blocked_count_out + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // Operation log
    // ------------------------------------------------------------
    reg [31:0] lg_time_q  [0:`BF_LOG_DEPTH-1];
    reg [2:0]  lg_event_q [0:`BF_LOG_DEPTH-1];
    reg [15:0] lg_phase_q [0:`BF_LOG_DEPTH-1];
    reg [15:0] lg_resid_q [0:`BF_LOG_DEPTH-1];
    reg [15:0] lg_rt_q    [0:`BF_LOG_DEPTH-1];
    reg [15:0] lg_bf_q    [0:`BF_LOG_DEPTH-1];
    reg [2:0]  lg_group_q [0:`BF_LOG_DEPTH-1];
    reg [3:0]  wr_ptr_q;

    function [15:0] sat16;
        input [20:0] v;
        begin
            sat16 = (v[20:16] != 5'h00) ? 16'hffff : v[15:0];
        end
    endfunction

    genvar g;
    generate
        for (g = 0; g < `BF_LOG_DEPTH; g = g + 1) begin : log_entry
            always @(posedge clk_sys_in) begin
                if (srst_in) begin
                    lg_time_q[g]  <= 32'h0000_0000;
                    lg_event_q[g] <= 3'h0;
                    lg_phase_q[g] <= 16'h0000;
                    lg_resid_q[g] <= 16'h0000;
                    lg_rt_q[g]    <= 16'h0000;
                    lg_bf_q[g]    <= 16'h0000;
                    lg_group_q[g] <= 3'h0;
                end else if (ce_in && on_ev && wr_ptr_q == g) begin
                    lg_time_q[g]  <= stamp_q;
                    lg_event_q[g] <= ev_src;
                    lg_phase_q[g] <= max_phase_current_in;
                    lg_resid_q[g] <= residual_current_in;
                    lg_rt_q[g]    <= sat16(rt_left);
                    lg_bf_q[g]    <= sat16(bf_left);
                    lg_group_q[g] <= setting_group_in;
                end
            end
        end
    endgenerate

    wire [3:0] rd_idx = (log_index_in > `BF_LOG_LAST) ? `BF_LOG_LAST : log_index_in;

    always @(posedge clk_sys_in) begin
        if (srst_in) begin
            wr_ptr_q          <= 4'h0;
            log_time_out      <= 32'h0000_0000;
            log_event_out     <= 3'h0;
            log_phase_out     <= 16'h0000;
            log_resid_out     <= 16'h0000;
            log_to_retrip_out <= 16'h0000;
            log_to_fail_out   <= 16'h0000;
            log_group_out     <= 3'h0;
        end else if (ce_in) begin
            if (on_ev) begin
                wr_ptr_q <= (wr_ptr_q == `BF_LOG_LAST) ? 4'h0 : wr_ptr_q + 4'h1;
            end
            log_time_out      <= lg_time_q[rd_idx];
            log_event_out     <= lg_event_q[rd_idx];
            log_phase_out     <= lg_phase_q[rd_idx];
            log_resid_out     <= lg_resid_q[rd_idx];
            log_to_retrip_out <= lg_rt_q[rd_idx];
            log_to_fail_out   <= lg_bf_q[rd_idx];
            log_group_out     <= lg_group_q[rd_idx];
        end
    end

endmodule

`default_nettype wire

/* File: core/breaker_fail_defs.vh */
`ifndef BREAKER_FAIL_DEFS_VH
`define BREAKER_FAIL_DEFS_VH

// Timing
`define BF_CLK_MHZ        250
`define BF_TICK_US        1000
`define BF_STEP_MS        21'h00_0005
`define BF_RETRIP_DEF     16'h0014
`define BF_FAIL_DEF       16'h0028

// Pick-up criteria
`define BF_CRIT_CUR       2'h0
`define BF_CRIT_CUR_AND   2'h1
`define BF_CRIT_CUR_OR    2'h2
`define BF_CRIT_INPUT     2'h3

// Status bit positions, also the event source codes
`define BF_EV_START       3'h0
`define BF_EV_RETRIP      3'h1
`define BF_EV_FAIL        3'h2
`define BF_EV_BLOCK       3'h3
`define BF_EV_MONITOR     3'h4
`define BF_EV_SIGNAL      3'h5
`define BF_EV_PHASE       3'h6
`define BF_EV_RESID       3'h7

`define BF_EV_COUNT       8
`define BF_LOG_DEPTH      12
`define BF_LOG_LAST       4'h0b

`endif

/* File: tb/breaker_fail_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module breaker_fail_chk (
    // Clock, reset and inputs
    input wire logic        clk_sys_in, srst_in, ce_in, block_in, retrip_en_in,
    input wire logic        phase_pickup_in, residual_pickup_in, trip_monitor_in,
    input wire logic        counter_clear_in,
    input wire logic [1:0]  criterion_in,
    input wire logic [7:0]  event_on_mask_in, event_off_mask_in,
    // Outputs
    input wire logic        retrip_out, breaker_fail_output, start_out,
    input wire logic        event_valid_out, event_on_out,
    input wire logic [2:0]  event_code_out,
    input wire logic [15:0] start_count_out, retrip_count_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (srst_in);
    wire cur = phase_pickup_in || residual_pickup_in;
    sequence quiet_s;
        !retrip_out && !breaker_fail_output;
    endsequence
    sequence off_twice_s;
        !retrip_en_in [*2];
    endsequence
    block_start_a: assert property (ce_in && block_in |=> !start_out)
        else $error("start raised while blocked");
    cur_start_a: assert property (ce_in && criterion_in == 2'h0 && cur && !block_in |=> start_out)
        else $error("current pick-up gave no start");
    cur_drop_a: assert property (ce_in && criterion_in == 2'h0 && !cur |=> quiet_s)
        else $error("outputs held after current release");
    and_drop_a: assert property (ce_in && criterion_in == 2'h1
        && !(cur && trip_monitor_in) |=> quiet_s)
        else $error("outputs set without current and trip contact");
    or_hold_a: assert property (ce_in && criterion_in == 2'h2 && trip_monitor_in
        && !block_in && breaker_fail_output |=> breaker_fail_output)
        else $error("breaker-fail dropped while trip contact held");
    retrip_off_a: assert property (off_twice_s |-> !retrip_out)
        else $error("retrip while disabled");
    retrip_delay_a: assert property ($rose(retrip_out) |-> start_out && $past(start_out, 8))
        else $error("retrip without sustained start");
    event_mask_a: assert property (event_valid_out |-> (event_on_out ?
        event_on_mask_in[event_code_out] : event_off_mask_in[event_code_out]))
        else $error("masked event reported");
    count_clear_a: assert property (ce_in && counter_clear_in |=>
        start_count_out == 16'h0000 && retrip_count_out == 16'h0000)
        else $error("counters not cleared");
endmodule
bind breaker_fail_timing breaker_fail_chk u_breaker_fail_chk (.clk_sys_in(clk_sys_in),
    .srst_in(srst_in), .ce_in(ce_in), .block_in(block_in), .retrip_en_in(retrip_en_in),
    .phase_pickup_in(phase_pickup_in), .residual_pickup_in(residual_pickup_in),
    .trip_monitor_in(trip_monitor_in), .counter_clear_in(counter_clear_in),
    .criterion_in(criterion_in), .event_on_mask_in(event_on_mask_in),
    .event_off_mask_in(event_off_mask_in), .retrip_out(retrip_out),
    .breaker_fail_output(breaker_fail_output), .start_out(start_out),
    .event_valid_out(event_valid_out), .event_on_out(event_on_out),
    .event_code_out(event_code_out), .start_count_out(start_count_out),
    .retrip_count_out(retrip_count_out));
`default_nettype wire

/* File: tb/breaker_model.sv */
`timescale 1ns/10ps
`default_nettype none
module breaker_model #(parameter int OPEN_CYC = 6) (
    input  wire logic clk_sys_in,
    input  wire logic fault_in,
    input  wire logic coil_ok_in,
    input  wire logic retrip_in,
    input  wire logic fail_in,
    output logic      current_out
);
    int n = 0;
    // A healthy coil opens the breaker some cycles after it is energised
    always @(posedge clk_sys_in) begin
        if (!fault_in) n <= 0;
        else if ((n > 0 || (coil_ok_in && (retrip_in || fail_in))) && n < OPEN_CYC) n <= n + 1;
    end
    assign current_out = fault_in && n < OPEN_CYC;
endmodule
`default_nettype wire

/* File: tb/tb_breaker_fail_timing.sv */
`timescale 1ns/10ps
`default_nettype none
`include "breaker_fail_defs.vh"
module tb_breaker_fail_timing;
    localparam int MS = 4;
    logic clk_sys_in = 0, srst_in = 1, fault = 0, res = 0, coil_ok = 0, mon = 0, ext = 0;
    logic blk = 0, ren = 1, clr = 0, ce = 1, ph_cur, rt, bf, st, bl, ev_v, ev_on, t_ok;
    logic [1:0]  crit = 0;
    logic [15:0] rd = 1, fd = 2, pval = 0, rval = 0, c_start, l_phase, l_resid;
    logic [15:0] c_rt, c_bf, c_bl, l_tr, l_tf;
    logic [7:0]  on_mask = 8'hff, off_mask = 8'hff, seen_on, seen_off;
    logic [2:0]  grp = 0, ev_code, l_event, l_group;
    logic [3:0]  l_idx = 0;
    logic [31:0] seed = 32'h2438_e04f, ev_time, l_time;
    int n_fail = 0, n_checks = 0, tr, tf, cyc = 0;
    always #2 clk_sys_in = ~clk_sys_in;
    always @(posedge clk_sys_in) cyc <= srst_in ? 0 : cyc + 1;
    breaker_model u_breaker_model (.clk_sys_in(clk_sys_in), .fault_in(fault),
        .coil_ok_in(coil_ok), .retrip_in(rt), .fail_in(bf), .current_out(ph_cur));
    breaker_fail_timing #(.MS_CYCLES(MS)) u_breaker_fail_timing (.clk_sys_in(clk_sys_in),
        .srst_in(srst_in), .ce_in(ce), .phase_pickup_in(ph_cur), .residual_pickup_in(res),
        .trip_monitor_in(mon), .ext_trip_in(ext), .block_in(blk), .criterion_in(crit),
        .retrip_en_in(ren), .redundant_trip_delay_in(rd), .fail_delay_in(fd),
        .event_on_mask_in(on_mask), .event_off_mask_in(off_mask), .setting_group_in(grp),
        .max_phase_current_in(pval), .residual_current_in(rval), .counter_clear_in(clr),
        .log_index_in(l_idx), .retrip_out(rt), .breaker_fail_output(bf), .start_out(st),
        .blocked_out(bl), .event_valid_out(ev_v), .event_code_out(ev_code),
        .event_on_out(ev_on), .event_time_out(ev_time), .retrip_count_out(c_rt),
        .fail_count_out(c_bf), .start_count_out(c_start), .blocked_count_out(c_bl),
        .log_time_out(l_time), .log_event_out(l_event), .log_phase_out(l_phase),
        .log_resid_out(l_resid), .log_to_retrip_out(l_tr), .log_to_fail_out(l_tf),
        .log_group_out(l_group));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic in_win(int t, int s);
        // First tick lands 1 to MS cycles after pick-up, output follows one cycle later
        return t >= s * 5 * MS - MS + 2 && t <= s * 5 * MS + 1;
    endfunction
    task check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task results;
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task step(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask
    task measure;
        tr = -1;
        tf = -1;
        for (int k = 1; k <= int'(fd) * 5 * MS + 12; k++) begin
            step(1);
            if (tr < 0 && rt === 1'b1) tr = k;
            if (tf < 0 && bf === 1'b1) tf = k;
        end
    endtask
    task watch(input int n);
        repeat (n) begin
            step(1);
            if (ev_v === 1'b1) begin
                if (ev_on === 1'b1) seen_on[ev_code] = 1;
                else seen_off[ev_code] = 1;
                t_ok = ev_time + 2 >= cyc / MS && ev_time <= cyc / MS + 2;
            end
        end
    endtask
    task trial(input logic [1:0] c, input logic en, cur, r, m, x);
        crit = c;
        ren = en;
        rd = 16'(1 + rnd() % 2);
        fd = rd + 16'(1 + rnd() % 2);
        step(3);
        fault = cur; res = r; mon = m; ext = x;
        measure;
        check("retrip_time", (en && c != 2'h3) ? in_win(tr, rd) : tr < 0, 1);
        check("fail_time", in_win(tf, fd), 1);
        fault = 0; res = 0; mon = 0; ext = 0;
        step(2);
        check("drop", {rt, bf}, 0);
    endtask
    task nofail(input logic [1:0] c, input logic m, b, k);
        crit = c; mon = m; blk = b; coil_ok = k;
        ren = 1;
        step(2);
        fault = 1;
        measure;
        check("blocked", bl, b);
        check("no_fail", tf < 0, 1);
        if (k) check("retrip_seen", tr > 0, 1);
        fault = 0; mon = 0; blk = 0; coil_ok = 0;
        step(3);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        step(2);
        srst_in = 0;
        trial(`BF_CRIT_CUR, 1, 1, 0, 0, 0);
        trial(`BF_CRIT_CUR, 1, 0, 1, 0, 0);
        trial(`BF_CRIT_CUR_AND, 1, 1, 0, 1, 0);
        trial(`BF_CRIT_CUR_OR, 1, 0, 0, 1, 0);
        trial(`BF_CRIT_CUR, 0, 1, 0, 0, 0);
        trial(`BF_CRIT_INPUT, 0, 0, 0, 0, 1);
        nofail(`BF_CRIT_CUR_AND, 0, 0, 0);
        nofail(`BF_CRIT_INPUT, 0, 0, 0);
        nofail(`BF_CRIT_CUR, 0, 1, 0);
        nofail(`BF_CRIT_CUR, 0, 0, 1);
        crit = `BF_CRIT_CUR_OR; fault = 1; mon = 1;
        measure;
        fault = 0;
        step(3);
        check("or_hold", bf, 1);
        mon = 0;
        step(2);
        check("or_release", bf, 0);
        check("retrip_count", c_rt, 6);
        check("fail_count", c_bf, 7);
        check("blocked_count", c_bl, 1);
        srst_in = 1;
        step(2);
        srst_in = 0;
        on_mask = 8'hbf;
        off_mask = 8'hfe;
        crit = `BF_CRIT_CUR;
        for (int i = 0; i < 7; i++) begin
            pval = 16'(rnd()); rval = 16'(rnd()); grp = 3'(rnd());
            seen_on = 0; seen_off = 0; t_ok = 0;
            step(2);
            fault = 1;
            watch(4);
            fault = 0;
            watch(6);
            check("events_on", seen_on, 8'h01);
            check("events_off", seen_off, 8'h40);
            check("stamp", t_ok, 1);
        end
        check("start_count", c_start, 7);
        l_idx = 0;
        step(2);
        check("log0", {l_event, l_phase, l_resid, l_group}, {3'h6, pval, rval, grp});
        check("log0_left", {l_tr, l_tf}, {16'(rd * 5), 16'(fd * 5)});
        check("log0_time", ev_time - l_time <= 2, 1);
        l_idx = 1;
        step(2);
        check("log1", l_event, 0);
        ce = 0;
        clr = 1;
        step(2);
        check("freeze", c_start, 7);
        ce = 1;
        step(1);
        clr = 0;
        step(1);
        check("count_clear", c_start, 0);
        results;
    end
    initial begin
        #400000;
        n_fail++;
        results;
    end
endmodule
`default_nettype wire
